// File: shared/hme_pkg.sv
// constants, states and helpers for the host message ring engine
// assumes an apb slave view of 8-bit byte addresses, 32-bit data
package hme_pkg;

  // apb register byte addresses
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_RING0     = 8'h04;
  localparam logic [7:0] RING_STRIDE = 8'h14;
  localparam logic [7:0] F_BASE      = 8'h00;
  localparam logic [7:0] F_HDR       = 8'h04;
  localparam logic [7:0] F_NTYPE     = 8'h08;
  localparam logic [7:0] F_NVAL      = 8'h0C;
  localparam logic [7:0] F_NADDR     = 8'h10;
  localparam logic [7:0] A_NOTIFY    = 8'h2C;
  localparam logic [7:0] A_CLEAR     = 8'h30;
  localparam logic [7:0] A_HEADS     = 8'h34;
  localparam logic [7:0] A_STATE     = 8'h38;

  // control bits
  localparam int CTRL_ARM  = 0;
  localparam int CTRL_ABS  = 1;
  localparam int CTRL_SWAP = 2;
  localparam logic [2:0]  RST_CTRL = 3'h0;
  localparam logic [31:0] RST_WORD = 32'h0;

  // descriptor layout, offsets from the descriptor start
  localparam logic [15:0] DESC_LINK = 16'h0000;
  localparam logic [15:0] DESC_RSVD = 16'h0002;
  localparam logic [15:0] DESC_STAT = 16'h0003;
  localparam logic [15:0] DESC_LEN  = 16'h0004;
  localparam logic [15:0] DESC_DATA = 16'h0006;

  // status byte bits
  localparam int ST_OWN  = 0;
  localparam int ST_DONE = 1;
  localparam int ST_OVF  = 2;

  // notification kinds
  localparam logic [1:0] NT_NONE  = 2'h0;
  localparam logic [1:0] NT_IO    = 2'h1;
  localparam logic [1:0] NT_MEM   = 2'h2;
  localparam logic [1:0] NT_LEVEL = 2'h3;

  localparam logic RING_H2D = 1'b0;
  localparam logic RING_D2H = 1'b1;

  typedef enum logic [2:0] {
    S_IDLE, S_STAT, S_FETCH, S_H_DATA, S_D_DATA, S_D_LEN, S_RET, S_NOTE
  } hme_state_e;

  // host byte address: segmented (segment*16 + offset) or 24-bit absolute
  function automatic logic [23:0] addr_of(input logic [31:0] a, input logic [15:0] off,
                                          input logic absm);
    if (absm)
      return a[23:0] + {8'h00, off};
    return {4'h0, a[31:16], 4'h0} + {8'h00, a[15:0]} + {8'h00, off};
  endfunction

  function automatic logic reg_hit(input logic [7:0] pa, input logic r, input logic [7:0] f);
    return pa == A_RING0 + (r ? RING_STRIDE : 8'h00) + f;
  endfunction

endpackage

// File: design/hme_msg_ram.sv
// staging memory for an outgoing message, one write and one read port
// read data are registered: address in one cycle, data the next
`timescale 1ns/1ps
`default_nettype none
module hme_msg_ram #(
  parameter int DW    = 8,
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// File: design/hme_ring_engine.sv
// device end of a two-ring message exchange in shared host memory
// assumes a byte-wide host memory port answering with mem_ack, apb config
// Functional notes
// - per ring notify: none, io, memory, level
// - level line held until clear port write
// - pending bit readable at notify port
// - io/memory notify writes configured value, low byte only
// - io notify uses low address word only
// - memory notify address follows address mode
// - config fields read back unchanged
// - link 0, reserved 2, status 3, length 4, data 6
// - offsets are 16-bit within one segment
// - status bit 0 ownership, 1 means device
// - handing back clears owner and done
// - overflow bit set on truncated message
// - length is byte count both directions
// - data passed raw, optional address-bit swap
// - never store more bytes than length
// - only header descriptor looked at, link advances
// - outgoing: own, fill, flag, release, notify
// - on notify consume until host-owned
`timescale 1ns/1ps
`default_nettype none
module hme_ring_engine #(
  parameter int MSG_DEPTH = 64
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_io,
  output logic      [23:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack,
  output logic             irq_level,
  output logic             rx_valid,
  output logic      [7:0]  rx_data,
  output logic             rx_last,
  input  wire logic        rx_ready,
  input  wire logic        usr_wr_en,
  input  wire logic [$clog2(MSG_DEPTH)-1:0] usr_wr_addr,
  input  wire logic [7:0]  usr_wr_data,
  input  wire logic        usr_send,
  input  wire logic [15:0] usr_len,
  output logic             usr_busy
);
  localparam int AW = $clog2(MSG_DEPTH);

  // configuration registers
  logic [2:0]        ctrl_q, ctrl_d;
  logic [1:0][31:0]  base_q, base_d, naddr_q, naddr_d;
  logic [1:0][15:0]  hdr_q, hdr_d, nval_q, nval_d;
  logic [1:0][1:0]   ntype_q, ntype_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              mapped;
  logic              wr_acc, note_wr, clr_wr, arm_load;

  // engine state
  hme_pkg::hme_state_e st_q, st_d;
  logic              ring_q, ring_d;
  logic [1:0]        k_q, k_d;
  logic [15:0]       link_q, link_d, len_q, len_d, idx_q, idx_d, desc_q, desc_d;
  logic [15:0]       mlen_q, mlen_d;
  logic [1:0][15:0]  head_q, head_d;
  logic              ovf_q, ovf_d, rxv_q, rxv_d;
  logic [7:0]        rxd_q, rxd_d;
  logic              h_pend_q, h_pend_d, d_kick_q, d_kick_d, d_req_q, d_req_d;
  logic [1:0]        irq_q, irq_d;
  logic              acc_q, acc_d, we_q, we_d, io_q, io_d;
  logic [23:0]       addr_q, addr_d;
  logic [7:0]        wd_q, wd_d;
  logic              go, go_we, go_io, go_raw, ack, start;
  logic [15:0]       go_off, cnt, swap_m;
  logic [7:0]        go_wd, ram_rdata;
  logic [1:0]        set_irq;
  logic              clr_h, clr_k;

  assign wr_acc   = psel && penable && pwrite;
  assign note_wr  = wr_acc && paddr == hme_pkg::A_NOTIFY;
  assign clr_wr   = wr_acc && paddr == hme_pkg::A_CLEAR;
  assign arm_load = wr_acc && paddr == hme_pkg::A_CTRL && pwdata[hme_pkg::CTRL_ARM]
                    && !ctrl_q[hme_pkg::CTRL_ARM];
  // zero-wait slave: read data captured in the setup cycle
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = prdata_q;

  always_comb begin
    ctrl_d   = ctrl_q;
    base_d   = base_q;
    hdr_d    = hdr_q;
    ntype_d  = ntype_q;
    nval_d   = nval_q;
    naddr_d  = naddr_q;
    prdata_d = prdata_q;
    mapped   = paddr == hme_pkg::A_CTRL || paddr == hme_pkg::A_NOTIFY ||
               paddr == hme_pkg::A_CLEAR || paddr == hme_pkg::A_HEADS ||
               paddr == hme_pkg::A_STATE;
    if (psel && !penable) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        hme_pkg::A_CTRL:   prdata_d = {29'h0, ctrl_q};
        hme_pkg::A_NOTIFY: prdata_d = {30'h0, irq_q};
        hme_pkg::A_HEADS:  prdata_d = {head_q[1], head_q[0]};
        hme_pkg::A_STATE:  prdata_d = {28'h0, d_kick_q, h_pend_q, d_req_q, st_q != hme_pkg::S_IDLE};
        default:           prdata_d = 32'h0000_0000;
      endcase
    end
    for (int r = 0; r < 2; r++) begin
      if (hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_BASE) ||
          hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_HDR) ||
          hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_NTYPE) ||
          hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_NVAL) ||
          hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_NADDR)) begin
        mapped = 1'b1;
      end
      if (psel && !penable) begin
        if (hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_BASE))  prdata_d = base_q[r];
        if (hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_HDR))   prdata_d = {16'h0, hdr_q[r]};
        if (hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_NTYPE)) prdata_d = {30'h0, ntype_q[r]};
        if (hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_NVAL))  prdata_d = {16'h0, nval_q[r]};
        if (hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_NADDR)) prdata_d = naddr_q[r];
      end
      if (wr_acc) begin
        if (hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_BASE))  base_d[r]  = pwdata;
        if (hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_HDR))   hdr_d[r]   = pwdata[15:0];
        if (hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_NTYPE)) ntype_d[r] = pwdata[1:0];
        if (hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_NVAL))  nval_d[r]  = pwdata[15:0];
        if (hme_pkg::reg_hit(paddr, r[0], hme_pkg::F_NADDR)) naddr_d[r] = pwdata;
      end
    end
    if (wr_acc && paddr == hme_pkg::A_CTRL) begin
      ctrl_d = pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= hme_pkg::RST_CTRL;
      base_q   <= '0;
      hdr_q    <= '0;
      ntype_q  <= '0;
      nval_q   <= '0;
      naddr_q  <= '0;
      prdata_q <= hme_pkg::RST_WORD;
    end else begin
      ctrl_q   <= ctrl_d;
      base_q   <= base_d;
      hdr_q    <= hdr_d;
      ntype_q  <= ntype_d;
      nval_q   <= nval_d;
      naddr_q  <= naddr_d;
      prdata_q <= prdata_d;
    end
  end

  // byte order swap by inverting address bit 0
  assign swap_m = {15'h0, ctrl_q[hme_pkg::CTRL_SWAP]};
  // bytes stored capped at descriptor length
  assign cnt    = (mlen_q < len_q) ? mlen_q : len_q;
  assign ack    = acc_q && mem_ack;
  assign start  = usr_send && !d_req_q;

  always_comb begin
    st_d = st_q;  ring_d = ring_q;  k_d = k_q;  link_d = link_q;  len_d = len_q;
    idx_d = idx_q;  desc_d = desc_q;  head_d = head_q;  ovf_d = ovf_q;  mlen_d = mlen_q;
    rxv_d = rxv_q;  rxd_d = rxd_q;  d_req_d = d_req_q;
    acc_d = acc_q && !mem_ack;  we_d = we_q;  io_d = io_q;  addr_d = addr_q;  wd_d = wd_q;
    go = 1'b0;  go_we = 1'b0;  go_io = 1'b0;  go_raw = 1'b0;  go_off = 16'h0;  go_wd = 8'h00;
    set_irq = 2'b00;  clr_h = 1'b0;  clr_k = 1'b0;
    unique case (st_q)
      hme_pkg::S_IDLE: begin
        if (ctrl_q[hme_pkg::CTRL_ARM]) begin
          if (h_pend_q) begin
            clr_h  = 1'b1;
            ring_d = hme_pkg::RING_H2D;
            desc_d = head_q[0];
            st_d   = hme_pkg::S_STAT;
          end else if (d_req_q && d_kick_q) begin
            clr_k  = 1'b1;
            ring_d = hme_pkg::RING_D2H;
            desc_d = head_q[1];
            st_d   = hme_pkg::S_STAT;
          end
        end
      end
      // only device-owned header descriptor is used
      hme_pkg::S_STAT: begin
        go     = 1'b1;
        go_off = hme_pkg::DESC_STAT;
        if (ack) begin
          k_d  = 2'h0;
          st_d = mem_rdata[hme_pkg::ST_OWN] ? hme_pkg::S_FETCH : hme_pkg::S_IDLE;
        end
      end
      // link and length read low byte first
      hme_pkg::S_FETCH: begin
        go     = 1'b1;
        go_off = (k_q[1] ? hme_pkg::DESC_LEN : hme_pkg::DESC_LINK) + {15'h0, k_q[0]};
        if (ack) begin
          k_d = k_q + 2'h1;
          unique case (k_q)
            2'h0: link_d[7:0]  = mem_rdata;
            2'h1: link_d[15:8] = mem_rdata;
            2'h2: len_d[7:0]   = mem_rdata;
            2'h3: len_d[15:8]  = mem_rdata;
          endcase
          if (k_q == 2'h3) begin
            head_d[ring_q] = link_q;
            idx_d = 16'h0;
            ovf_d = 1'b0;
            st_d  = ring_q ? hme_pkg::S_D_DATA : hme_pkg::S_H_DATA;
          end
        end
      end
      // stall while no consumer takes the byte
      hme_pkg::S_H_DATA: begin
        if (len_q == 16'h0) begin
          st_d = hme_pkg::S_RET;
        end else if (rxv_q) begin
          if (rx_ready) begin
            rxv_d = 1'b0;
            if (idx_q == len_q - 16'h1) st_d = hme_pkg::S_RET;
            else idx_d = idx_q + 16'h1;
          end
        end else begin
          go     = 1'b1;
          go_off = hme_pkg::DESC_DATA + (idx_q ^ swap_m);
          if (ack) begin
            rxv_d = 1'b1;
            rxd_d = mem_rdata;
          end
        end
      end
      // fill data, then length and flags
      hme_pkg::S_D_DATA: begin
        if (idx_q == cnt) begin
          ovf_d = mlen_q > len_q;
          k_d   = 2'h0;
          st_d  = hme_pkg::S_D_LEN;
        end else begin
          go     = 1'b1;
          go_we  = 1'b1;
          go_off = hme_pkg::DESC_DATA + (idx_q ^ swap_m);
          go_wd  = ram_rdata;
          if (ack) idx_d = idx_q + 16'h1;
        end
      end
      hme_pkg::S_D_LEN: begin
        go     = 1'b1;
        go_we  = 1'b1;
        go_off = hme_pkg::DESC_LEN + {15'h0, k_q[0]};
        go_wd  = k_q[0] ? idx_q[15:8] : idx_q[7:0];
        if (ack) begin
          k_d = k_q + 2'h1;
          if (k_q[0]) st_d = hme_pkg::S_RET;
        end
      end
      // release with owner and done cleared
      hme_pkg::S_RET: begin
        go     = 1'b1;
        go_we  = 1'b1;
        go_off = hme_pkg::DESC_STAT;
        go_wd  = {5'h00, ovf_q, 2'b00};
        if (ack) begin
          if (ring_q) d_req_d = 1'b0;
          st_d = hme_pkg::S_NOTE;
        end
      end
      // notify as configured for this ring
      hme_pkg::S_NOTE: begin
        if (ntype_q[ring_q] == hme_pkg::NT_IO || ntype_q[ring_q] == hme_pkg::NT_MEM) begin
          go     = 1'b1;
          go_we  = 1'b1;
          go_raw = 1'b1;
          go_io  = ntype_q[ring_q] == hme_pkg::NT_IO;
          go_wd  = nval_q[ring_q][7:0];
        end else if (ntype_q[ring_q] == hme_pkg::NT_LEVEL) begin
          set_irq[ring_q] = 1'b1;
        end
        if (ack || !go) begin
          desc_d = head_q[0];
          st_d   = ring_q ? hme_pkg::S_IDLE : hme_pkg::S_STAT;
        end
      end
    endcase
    if (go && !acc_q) begin
      acc_d = 1'b1;
      we_d  = go_we;
      io_d  = go_io;
      wd_d  = go_wd;
      // notify writes go to the configured target
      if (go_raw && go_io) begin
        addr_d = {8'h00, naddr_q[ring_q][15:0]};
      end else if (go_raw) begin
        addr_d = hme_pkg::addr_of(naddr_q[ring_q], 16'h0, ctrl_q[hme_pkg::CTRL_ABS]);
      end else begin
        // 16-bit offsets inside the ring segment
        addr_d = hme_pkg::addr_of(base_q[ring_q], desc_q + go_off, ctrl_q[hme_pkg::CTRL_ABS]);
      end
    end
    if (start) begin
      d_req_d = 1'b1;
      mlen_d  = usr_len;
    end
    if (arm_load) head_d = hdr_q;
  end

  // set wins over clear on every flag
  assign h_pend_d = (h_pend_q && !clr_h) || note_wr;
  assign d_kick_d = (d_kick_q && !clr_k) || note_wr || start;
  // level held until the clear port is written
  assign irq_d    = (irq_q & ~{2{clr_wr}}) | set_irq;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= hme_pkg::S_IDLE;  ring_q <= 1'b0;  k_q <= 2'h0;  link_q <= 16'h0;
      len_q <= 16'h0;  idx_q <= 16'h0;  desc_q <= 16'h0;  head_q <= '0;  ovf_q <= 1'b0;
      mlen_q <= 16'h0;  rxv_q <= 1'b0;  rxd_q <= 8'h00;  h_pend_q <= 1'b0;  d_kick_q <= 1'b0;
      d_req_q <= 1'b0;  irq_q <= 2'b00;  acc_q <= 1'b0;  we_q <= 1'b0;  io_q <= 1'b0;
      addr_q <= 24'h0;  wd_q <= 8'h00;
    end else begin
      st_q <= st_d;  ring_q <= ring_d;  k_q <= k_d;  link_q <= link_d;
      len_q <= len_d;  idx_q <= idx_d;  desc_q <= desc_d;  head_q <= head_d;  ovf_q <= ovf_d;
      mlen_q <= mlen_d;  rxv_q <= rxv_d;  rxd_q <= rxd_d;  h_pend_q <= h_pend_d;
      d_kick_q <= d_kick_d;  d_req_q <= d_req_d;  irq_q <= irq_d;  acc_q <= acc_d;
      we_q <= we_d;  io_q <= io_d;  addr_q <= addr_d;  wd_q <= wd_d;
    end
  end

  // read address runs one step ahead so data match idx_q
  hme_msg_ram #(.DW(8), .DEPTH(MSG_DEPTH)) u_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (usr_wr_en),
    .wr_addr (usr_wr_addr),
    .wr_data (usr_wr_data),
    .rd_addr (idx_d[AW-1:0]),
    .rd_data (ram_rdata)
  );

  assign mem_req   = acc_q;
  assign mem_we    = we_q;
  assign mem_io    = io_q;
  assign mem_addr  = addr_q;
  assign mem_wdata = wd_q;
  assign irq_level = |irq_q;
  assign rx_valid  = rxv_q;
  assign rx_data   = rxd_q;
  assign rx_last   = rxv_q && idx_q == len_q - 16'h1;
  assign usr_busy  = d_req_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ret_ack;
    st_q == hme_pkg::S_RET && ack;
  endsequence

  chk_irq_hold: assert property (irq_level && !clr_wr |=> irq_level)
    else $error("level line dropped without clear");
  chk_irq_pend: assert property (st_q == hme_pkg::S_NOTE && ntype_q[ring_q] == hme_pkg::NT_LEVEL
      |=> irq_q != 2'b00 && irq_level)
    else $error("pending bit not set on level notify");
  chk_note_value: assert property (st_q == hme_pkg::S_NOTE && mem_req && (ntype_q[ring_q] ==
      hme_pkg::NT_IO || ntype_q[ring_q] == hme_pkg::NT_MEM) |-> mem_we
      && mem_wdata == nval_q[ring_q][7:0])
    else $error("notify write carries wrong value");
  chk_io_addr: assert property (st_q == hme_pkg::S_NOTE && mem_req &&
      ntype_q[ring_q] == hme_pkg::NT_IO |-> mem_io && mem_addr[23:16] == 8'h00
      && mem_addr[15:0] == naddr_q[ring_q][15:0])
    else $error("io notify address wrong");
  chk_seg_addr: assert property (st_q == hme_pkg::S_NOTE && mem_req && !mem_io &&
      !ctrl_q[hme_pkg::CTRL_ABS] |-> mem_addr == {4'h0, naddr_q[ring_q][31:16], 4'h0}
      + {8'h00, naddr_q[ring_q][15:0]})
    else $error("segmented notify address wrong");
  chk_cfg_keep: assert property (!wr_acc |=> $stable(ntype_q) && $stable(base_q)
      && $stable(naddr_q))
    else $error("config changed without a write");
  chk_ret_flags: assert property (s_ret_ack |-> mem_we && mem_wdata[1:0] == 2'b00
      ##1 st_q == hme_pkg::S_NOTE)
    else $error("release did not clear owner and done");
  chk_ovf_flag: assert property (st_q == hme_pkg::S_RET && mem_req && ring_q |->
      mem_wdata[hme_pkg::ST_OVF] == (mlen_q > len_q))
    else $error("overflow flag wrong");
  chk_trunc_cap: assert property (st_q == hme_pkg::S_D_DATA && mem_req |-> idx_q < len_q
      && idx_q < mlen_q)
    else $error("stored past descriptor length");
  chk_head_adv: assert property (st_q == hme_pkg::S_FETCH && ack && k_q == 2'h3 && !arm_load
      |=> head_q[ring_q] == $past(link_q))
    else $error("header not advanced to link");
  chk_rx_stall: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("message byte lost under stall");
endmodule
`default_nettype wire

// File: dv/hme_host_mem.sv
// host memory model facing the engine's byte port, io writes latched apart
// assumes one request at a time, held by the engine until mem_ack
`timescale 1ns/1ps
`default_nettype none
module hme_host_mem (
  input  wire logic        pclk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_io,
  input  wire logic [23:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [3:0]  lat,
  output logic      [7:0]  mem_rdata,
  output logic             mem_ack
);
  logic [7:0]  mem [0:4095];
  logic [15:0] io_addr;
  logic [7:0]  io_data;
  int          cnt;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    io_data = 8'h00;
    cnt = 0;
  end
  // no ack while our own ack is still out, the request drops after it
  always @(posedge pclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req === 1'b1 && !mem_ack) begin
      if (cnt < lat) begin
        cnt <= cnt + 1;
      end else begin
        cnt <= 0;
        mem_ack <= 1'b1;
        if (mem_we && mem_io) begin
          io_addr <= mem_addr[15:0];
          io_data <= mem_wdata;
        end else if (mem_we) begin
          mem[mem_addr[11:0]] <= mem_wdata;
        end else begin
          mem_rdata <= mem[mem_addr[11:0]];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// random and corner traffic through both rings, apb config and notify kinds
// assumes the host memory model instance mdl owns the shared bytes
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slverr;
  logic        pready, pslverr, mem_req, mem_we, mem_io, mem_ack, irq_level;
  logic        rx_valid, rx_last, rx_ready = 0, usr_wr_en = 0, usr_send = 0, usr_busy, sw = 0;
  logic [7:0]  paddr = 0, mem_wdata, mem_rdata, rx_data, usr_wr_data = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [23:0] mem_addr;
  logic [5:0]  usr_wr_addr = 0;
  logic [15:0] usr_len = 0, rs = 16'h000D, rr = 16'h000D;
  logic [3:0]  lat = 0;
  logic [8:0]  rxq[$], exq[$];
  logic [31:0] msk [5] = '{32'hFFFFFFFF, 32'hFFFF, 32'h3, 32'hFFFF, 32'hFFFFFFFF};
  int          err_count = 0, num_checks = 0, i;
  hme_ring_engine uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .mem_req, .mem_we, .mem_io, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .irq_level, .rx_valid, .rx_data, .rx_last, .rx_ready, .usr_wr_en, .usr_wr_addr,
    .usr_wr_data, .usr_send, .usr_len, .usr_busy);
  hme_host_mem mdl (.pclk, .mem_req, .mem_we, .mem_io, .mem_addr, .mem_wdata, .lat,
    .mem_rdata, .mem_ack);
  initial forever #2.5 pclk = ~pclk;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // consumer and memory both stall at random
  always @(posedge pclk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back({rx_last, rx_data});
    // own sequence, so a stalled consumer cannot freeze between messages
    rr <= nx(rr);
    rx_ready <= rr[3] | rr[7];
    lat <= {1'b0, rr[6:4]};
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 3000) begin
      err_count++;
      finish_test();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 3000);
    tmo(n);
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input int r, input logic [7:0] f, input logic [31:0] v);
    apb(1, hme_pkg::A_RING0 + 8'(r) * hme_pkg::RING_STRIDE + f, v);
  endtask
  // sel 0 memory byte, 1 io port data, 2 level line
  task automatic wait_on(input int sel, input logic [11:0] a, input logic [7:0] v);
    int n;
    n = 0;
    while ((sel == 0 ? mdl.mem[a] : sel == 1 ? mdl.io_data : {7'h0, irq_level}) !== v
           && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    tmo(n);
  endtask
  task automatic desc(input logic [11:0] d, input logic [15:0] lnk, input logic [7:0] st);
    mdl.mem[d] = lnk[7:0];
    mdl.mem[d + 1] = lnk[15:8];
    mdl.mem[d + 2] = 8'h00;
    // length within a 4-byte data area
    mdl.mem[d + 4] = 8'h04;
    mdl.mem[d + 5] = 8'h00;
    // status last, bits 3-7 left zero
    mdl.mem[d + 3] = st;
  endtask
  task automatic h2d(input logic [11:0] d, input int n);
    exq = {};
    rxq = {};
    for (i = 0; i < n; i++) begin
      rs = nx(rs);
      // swap inverts data address bit 0
      mdl.mem[d + 6 + (i ^ sw)] = rs[7:0];
      exq.push_back({i == n - 1, rs[7:0]});
    end
    // link untouched, length and status only
    mdl.mem[d + 4] = 8'(n);
    mdl.mem[d + 3] = 8'h03;
    apb(1, hme_pkg::A_NOTIFY, 0);
    wait_on(0, d + 3, 8'h00);
    chk(mdl.mem[d + 3], 8'h00);
    chk(rxq.size(), n);
    for (i = 0; i < n; i++) chk(rxq[i], exq[i]);
  endtask
  task automatic d2h(input logic [11:0] d, input int n);
    exq = {};
    for (i = 0; i < n; i++) begin
      rs = nx(rs);
      usr_wr_en <= 1'b1;
      usr_wr_addr <= 6'(i);
      usr_wr_data <= rs[7:0];
      exq.push_back({1'b0, rs[7:0]});
      @(posedge pclk);
    end
    usr_wr_en <= 1'b0;
    usr_send <= 1'b1;
    usr_len <= 16'(n);
    @(posedge pclk);
    usr_send <= 1'b0;
    @(posedge pclk);
    chk(usr_busy, 1'b1);
    wait_on(0, d + 3, n > 4 ? 8'h04 : 8'h00);
    chk(mdl.mem[d + 3], n > 4 ? 8'h04 : 8'h00);
    chk({mdl.mem[d + 5], mdl.mem[d + 4]}, n > 4 ? 4 : n);
    for (i = 0; i < 4 && i < n; i++) chk(mdl.mem[d + 6 + (i ^ sw)], exq[i][7:0]);
    // busy drops at the edge after the status write lands
    @(posedge pclk);
    chk(usr_busy, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'hFC, 0);
    chk(slverr, 1'b1);
    chk(rd, 32'h0);
    for (int k = 0; k < 10; k++) begin
      rs = nx(rs);
      cfg(k / 5, 8'(4 * (k % 5)), {rs, ~rs});
      apb(0, hme_pkg::A_RING0 + 8'(k / 5) * hme_pkg::RING_STRIDE + 8'(4 * (k % 5)), 0);
      chk(rd, {rs, ~rs} & msk[k % 5]);
    end
    // rings built, headers agree, then arm
    desc(12'h110, 16'h0030, 8'h02);
    desc(12'h130, 16'h0010, 8'h02);
    desc(12'h810, 16'h0030, 8'h03);
    desc(12'h830, 16'h0010, 8'h03);
    cfg(0, hme_pkg::F_BASE, 32'h0010_0000);
    cfg(0, hme_pkg::F_HDR, 32'h10);
    cfg(0, hme_pkg::F_NTYPE, 32'(hme_pkg::NT_LEVEL));
    cfg(1, hme_pkg::F_BASE, 32'h0080_0000);
    cfg(1, hme_pkg::F_HDR, 32'h10);
    cfg(1, hme_pkg::F_NTYPE, 32'(hme_pkg::NT_IO));
    cfg(1, hme_pkg::F_NVAL, 32'h5A);
    cfg(1, hme_pkg::F_NADDR, 32'h1234_0077);
    apb(1, hme_pkg::A_CTRL, 32'h1);
    h2d(12'h110, 3);
    wait_on(2, 0, 8'h01);
    repeat (5) @(posedge pclk);
    chk(irq_level, 1'b1);
    apb(0, hme_pkg::A_NOTIFY, 0);
    chk(rd[0], 1'b1);
    apb(0, hme_pkg::A_HEADS, 0);
    chk(rd, 32'h0010_0030);
    apb(1, hme_pkg::A_CLEAR, 0);
    apb(0, hme_pkg::A_NOTIFY, 0);
    chk({rd[1:0], irq_level}, 3'h0);
    cfg(0, hme_pkg::F_NTYPE, 32'(hme_pkg::NT_NONE));
    h2d(12'h130, 1);
    repeat (8) @(posedge pclk);
    chk(irq_level, 1'b0);
    d2h(12'h810, 6);
    wait_on(1, 0, 8'h5A);
    chk(mdl.io_addr, 16'h0077);
    cfg(1, hme_pkg::F_NTYPE, 32'(hme_pkg::NT_MEM));
    cfg(1, hme_pkg::F_NVAL, 32'hA5);
    cfg(1, hme_pkg::F_NADDR, 32'h00F0_0004);
    d2h(12'h830, 2);
    wait_on(0, 12'hF04, 8'hA5);
    chk(mdl.mem[12'hF04], 8'hA5);
    apb(0, hme_pkg::A_HEADS, 0);
    chk(rd, 32'h0010_0010);
    cfg(0, hme_pkg::F_BASE, 32'h0000_0100);
    cfg(1, hme_pkg::F_BASE, 32'h0000_0800);
    cfg(1, hme_pkg::F_NADDR, 32'h0000_0F08);
    apb(1, hme_pkg::A_CTRL, 32'h7);
    sw = 1'b1;
    h2d(12'h110, 3);
    // host restores length before handing back
    desc(12'h810, 16'h0030, 8'h03);
    d2h(12'h810, 4);
    wait_on(0, 12'hF08, 8'hA5);
    chk(mdl.mem[12'hF08], 8'hA5);
    apb(0, hme_pkg::A_HEADS, 0);
    chk(rd, 32'h0030_0030);
    apb(0, hme_pkg::A_STATE, 0);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
